// file: ptt_defs.svh
// Offsets, field positions, reset values and timing counts of the trigger and timestamp block
`ifndef PTT_DEFS_SVH
`define PTT_DEFS_SVH

// ==========================================
// Register offsets
`define PTT_OFS_UNIT_INDEX    12'h520
`define PTT_OFS_CYCLE_WIDTH   12'h53c
`define PTT_OFS_COUNT_PATTERN 12'h540
`define PTT_OFS_ITERATION     12'h544
`define PTT_OFS_PULSE_WIDTHS  12'h548
`define PTT_OFS_TS_STATUS     12'h550

// ==========================================
// Field positions
`define PTT_IDX_TRIG_LSB      0
`define PTT_IDX_TS_BIT        8
`define PTT_COUNT_LSB         16
`define PTT_PW_UPPER_LSB      16
`define PTT_PW_MASK           32'h00ff_ffff
`define PTT_TS_CNT_LSB        17
`define PTT_TS_OVF_BIT        16
`define PTT_TS_RISE_BIT       7
`define PTT_TS_FALL_BIT       6
`define PTT_TS_LAST_BIT       5
`define PTT_TS_UPSEL_BIT      1
`define PTT_TS_JOIN_BIT       0

// ==========================================
// Reset values
`define PTT_RST_WORD          32'h0000_0000
`define PTT_RST_CNT           4'h0
`define PTT_CNT_MAX           4'hf

// ==========================================
// Output pattern codes
`define PTT_MODE_NEG_EDGE     3'h0
`define PTT_MODE_POS_EDGE     3'h1
`define PTT_MODE_NEG_PULSE    3'h2
`define PTT_MODE_POS_PULSE    3'h3
`define PTT_MODE_NEG_PERIOD   3'h4
`define PTT_MODE_POS_PERIOD   3'h5
`define PTT_MODE_PATTERN      3'h6

// ==========================================
// Timing
`define PTT_CLK_NS            8
`define PTT_PW_UNIT_NS        8
`define PTT_PW_UNIT_CLKS      (`PTT_PW_UNIT_NS / `PTT_CLK_NS)
`define PTT_SLOT_NS           8
`define PTT_SYS_PERIOD_NS     40
`define PTT_SLOTS             (`PTT_SYS_PERIOD_NS / `PTT_SLOT_NS)

`endif

// file: ptt_pkg.sv
// Types shared by the trigger and timestamp block
package ptt_pkg;
  typedef enum logic [2:0] {
    PTT_IDLE,
    PTT_LOAD,
    PTT_FIRE,
    PTT_RUN
  } ptt_state_e;

  typedef logic [31:0] ptt_word_t;
endpackage

// file: ptt_setmem.sv
// Per-unit trigger settings store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
`include "ptt_defs.svh"
module ptt_setmem (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Write port
  input  wire logic             we,
  input  wire logic [3:0]       waddr,
  input  wire ptt_pkg::ptt_word_t wdata,
  // Bus read port
  input  wire logic [3:0]       raddr_a,
  output ptt_pkg::ptt_word_t    rdata_a,
  // Engine read port
  input  wire logic [3:0]       raddr_b,
  output ptt_pkg::ptt_word_t    rdata_b
);
  ptt_pkg::ptt_word_t mem [16];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a <= `PTT_RST_WORD;
      rdata_b <= `PTT_RST_WORD;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule
`default_nettype wire

// file: ptt_top.sv
// Trigger output settings, trigger waveform engine and two timestamp input units
`timescale 1ns/1ps
`default_nettype none
`include "ptt_defs.svh"

// Behaviour
// - Trigger settings accesses go to the unit chosen by index bits [1:0].
// - Cycle or bit period is a 32-bit width in 1 ns units.
// - Emit count cycles or bits from 16-bit field; zero repeats forever.
// - Pattern mode shifts the 16-bit pattern in the count register low half.
// - Cascade next target is present target plus 32-bit iteration time.
// - Pulse width is 16 bits in 8 ns units, also periodic active phase.
// - Second-pulse width prepends an 8-bit upper byte to the pulse width.
// - Read-only 4-bit count of enabled edges seen, up to 15.
// - Input edges at up to 25 MHz are detected.
// - Overflow flag set on count overflow; in cascade only the tail unit.
// - After overflow the count holds at 15.
// - Rising and falling edges captured only while their enables are set.
// - Tail indicator bit marks the last unit of a cascade.
// - Upstream done comes from unit 1 if select is one, else unit 0.
// - A unit joins cascade only while its enable bit zero is set.
// - Periodic output: active width from pulse width, period from cycle width.
// - Each capture reports rising as one, falling as zero.
// - Each capture reports the 8 ns slot within the 40 ns period.
module ptt_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger start from the system-time compare logic
  input  wire logic        trig_start,
  input  wire logic [1:0]  trig_unit,
  input  wire logic [2:0]  trig_mode,
  input  wire logic        trig_second_pulse,
  input  wire logic        trig_cascade,
  input  wire logic [31:0] trig_target,
  // Trigger output
  output logic             trig_out,
  output logic             trig_busy,
  output logic      [31:0] chain_next_target,
  output logic             chain_next_valid,
  // Timestamp inputs and capture report
  input  wire logic [1:0]  ts_pin,
  output logic             cap_valid,
  output logic             cap_unit,
  output logic             sample_edge_polarity,
  output logic      [2:0]  sample_sub_slot_phase
);
  // ==========================================
  // Helpers
  function automatic logic [1:0] word_of(input logic [11:0] a);
    if (a == `PTT_OFS_CYCLE_WIDTH) word_of = 2'h0;
    else if (a == `PTT_OFS_COUNT_PATTERN) word_of = 2'h1;
    else if (a == `PTT_OFS_ITERATION) word_of = 2'h2;
    else word_of = 2'h3;
  endfunction

  function automatic logic is_set(input logic [11:0] a);
    is_set = (a == `PTT_OFS_CYCLE_WIDTH) || (a == `PTT_OFS_COUNT_PATTERN) ||
             (a == `PTT_OFS_ITERATION) || (a == `PTT_OFS_PULSE_WIDTHS);
  endfunction

  // ==========================================
  // Register state
  logic [1:0]  trig_idx;
  logic        ts_idx;
  logic [1:0]  acc_cnt;
  logic [1:0]  rise_on;
  logic [1:0]  fall_on;
  logic [1:0]  chain_last_flag;
  logic [1:0]  up_sel;
  logic [1:0]  chain_join;
  logic [3:0]  captured_edge_count [2];
  logic [1:0]  captured_edge_overflow;
  ptt_pkg::ptt_word_t rdata_a;
  ptt_pkg::ptt_word_t rdata_b;
  logic [3:0]  eng_raddr;
  logic        bus_take;
  logic        bus_wr;
  logic [31:0] mem_wdata;
  logic [31:0] ts_word;

  assign bus_take = psel && penable && pready;
  assign bus_wr   = bus_take && pwrite;
  assign mem_wdata = (paddr == `PTT_OFS_PULSE_WIDTHS) ? (pwdata & `PTT_PW_MASK) : pwdata;

  // ==========================================
  // Settings store
  // indexed settings access
  ptt_setmem u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (bus_wr && is_set(paddr)),
    .waddr   ({trig_idx, word_of(paddr)}),
    .wdata   (mem_wdata),
    .raddr_a ({trig_idx, word_of(paddr)}),
    .rdata_a (rdata_a),
    .raddr_b (eng_raddr),
    .rdata_b (rdata_b)
  );

  always_comb begin
    ts_word = '0;
    ts_word[`PTT_TS_CNT_LSB +: 4]  = captured_edge_count[ts_idx];
    ts_word[`PTT_TS_OVF_BIT]       = captured_edge_overflow[ts_idx];
    ts_word[`PTT_TS_RISE_BIT]      = rise_on[ts_idx];
    ts_word[`PTT_TS_FALL_BIT]      = fall_on[ts_idx];
    ts_word[`PTT_TS_LAST_BIT]      = chain_last_flag[ts_idx];
    ts_word[`PTT_TS_UPSEL_BIT]     = up_sel[ts_idx];
    ts_word[`PTT_TS_JOIN_BIT]      = chain_join[ts_idx];
  end

  // ==========================================
  // APB answer: ready two cycles into the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt <= 2'h0;
      pready  <= 1'b0;
      prdata  <= `PTT_RST_WORD;
      pslverr <= 1'b0;
    end else if (pready) begin
      acc_cnt <= 2'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable) begin
      acc_cnt <= acc_cnt + 2'h1;
      if (acc_cnt == 2'h1) begin
        pready  <= 1'b1;
        pslverr <= 1'b0;
        prdata  <= `PTT_RST_WORD;
        if (is_set(paddr)) begin
          prdata <= rdata_a;
        end else if (paddr == `PTT_OFS_TS_STATUS) begin
          prdata <= ts_word;
        end else if (paddr == `PTT_OFS_UNIT_INDEX) begin
          prdata[`PTT_IDX_TRIG_LSB +: 2] <= trig_idx;
          prdata[`PTT_IDX_TS_BIT]        <= ts_idx;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Unit index register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_idx <= 2'h0;
      ts_idx   <= 1'b0;
    end else if (bus_wr && paddr == `PTT_OFS_UNIT_INDEX) begin
      trig_idx <= pwdata[`PTT_IDX_TRIG_LSB +: 2];
      ts_idx   <= pwdata[`PTT_IDX_TS_BIT];
    end
  end

  // ==========================================
  // Trigger engine
  ptt_pkg::ptt_state_e st;
  logic [2:0]  ld_cnt;
  logic [1:0]  ld_unit;
  logic [2:0]  mode;
  logic        second_pulse;
  logic [31:0] cyc_w;
  logic [31:0] cnt_pat;
  logic [31:0] iter_t;
  logic [31:0] pw_reg;
  logic [31:0] ns_acc;
  logic [23:0] hold_cnt;
  logic [15:0] cyc_cnt;
  logic [3:0]  bit_idx;
  logic        act_lvl;
  logic [31:0] next_ns;
  logic        per_end;
  logic [23:0] pulse_clks;
  logic [23:0] per_clks;

  assign eng_raddr = {ld_unit, ld_cnt[1:0]};
  // Odd pattern codes are active high, codes 0, 2 and 4 active low
  assign act_lvl   = mode[0];
  assign next_ns   = ns_acc + 32'(`PTT_CLK_NS);
  assign per_end   = next_ns >= cyc_w;
  assign pulse_clks = 24'((second_pulse ? pw_reg[23:0] : {8'h00, pw_reg[15:0]}) * `PTT_PW_UNIT_CLKS);
  // pulse width in 8 ns units
  assign per_clks  = 24'({8'h00, pw_reg[15:0]} * `PTT_PW_UNIT_CLKS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ptt_pkg::PTT_IDLE;
      ld_cnt <= 3'h0;
      ld_unit <= 2'h0;
      mode <= `PTT_MODE_NEG_EDGE;
      second_pulse <= 1'b0;
      cyc_w <= `PTT_RST_WORD;
      cnt_pat <= `PTT_RST_WORD;
      iter_t <= `PTT_RST_WORD;
      pw_reg <= `PTT_RST_WORD;
      ns_acc <= `PTT_RST_WORD;
      hold_cnt <= 24'h0;
      cyc_cnt <= 16'h0;
      bit_idx <= 4'h0;
      trig_out <= 1'b0;
      trig_busy <= 1'b0;
      chain_next_target <= `PTT_RST_WORD;
      chain_next_valid <= 1'b0;
    end else begin
      chain_next_valid <= 1'b0;
      case (st)
        ptt_pkg::PTT_IDLE: begin
          if (trig_start && trig_mode != 3'h7) begin
            ld_unit <= trig_unit;
            mode <= trig_mode;
            second_pulse <= trig_second_pulse;
            ld_cnt <= 3'h0;
            trig_busy <= 1'b1;
            st <= ptt_pkg::PTT_LOAD;
          end
        end
        ptt_pkg::PTT_LOAD: begin
          ld_cnt <= ld_cnt + 3'h1;
          // Read data trails the engine address by one cycle
          if (ld_cnt == 3'h1) cyc_w <= rdata_b;
          if (ld_cnt == 3'h2) cnt_pat <= rdata_b;
          if (ld_cnt == 3'h3) iter_t <= rdata_b;
          if (ld_cnt == 3'h4) pw_reg <= rdata_b;
          if (ld_cnt == 3'h5) begin
            st <= ptt_pkg::PTT_FIRE;
          end
        end
        ptt_pkg::PTT_FIRE: begin
          ns_acc <= `PTT_RST_WORD;
          hold_cnt <= 24'h0;
          cyc_cnt <= 16'h0;
          // pattern shifted out first bit first
          trig_out <= (mode == `PTT_MODE_PATTERN) ? cnt_pat[15] : act_lvl;
          bit_idx <= 4'he;
          if (trig_cascade) begin
            chain_next_target <= trig_target + iter_t;
            chain_next_valid <= 1'b1;
          end
          if (mode == `PTT_MODE_NEG_EDGE || mode == `PTT_MODE_POS_EDGE) begin
            trig_busy <= 1'b0;
            st <= ptt_pkg::PTT_IDLE;
          end else begin
            st <= ptt_pkg::PTT_RUN;
          end
        end
        ptt_pkg::PTT_RUN: begin
          hold_cnt <= hold_cnt + 24'h1;
          if (mode == `PTT_MODE_NEG_PULSE || mode == `PTT_MODE_POS_PULSE) begin
            if (hold_cnt + 24'h1 >= pulse_clks) begin
              trig_out <= ~act_lvl;
              trig_busy <= 1'b0;
              st <= ptt_pkg::PTT_IDLE;
            end
          end else if (per_end) begin
            ns_acc <= `PTT_RST_WORD;
            hold_cnt <= 24'h0;
            cyc_cnt <= cyc_cnt + 16'h1;
            bit_idx <= bit_idx - 4'h1;
            if (cnt_pat[`PTT_COUNT_LSB +: 16] != 16'h0 &&
                cyc_cnt + 16'h1 == cnt_pat[`PTT_COUNT_LSB +: 16]) begin
              trig_out <= (mode == `PTT_MODE_PATTERN) ? 1'b0 : ~act_lvl;
              trig_busy <= 1'b0;
              st <= ptt_pkg::PTT_IDLE;
            end else begin
              trig_out <= (mode == `PTT_MODE_PATTERN) ? cnt_pat[bit_idx] : act_lvl;
            end
          end else begin
            ns_acc <= next_ns;
            if (mode != `PTT_MODE_PATTERN) begin
              trig_out <= (hold_cnt + 24'h1 < per_clks) ? act_lvl : ~act_lvl;
            end
          end
        end
        default: st <= ptt_pkg::PTT_IDLE;
      endcase
    end
  end

  // ==========================================
  // Timestamp inputs
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] lvl;
  logic [1:0] edge_r;
  logic [1:0] edge_f;
  logic [1:0] take;
  logic [2:0] slot;

  // three-stage sampling of 25 MHz edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
      lvl <= 2'h0;
    end else begin
      s1 <= ts_pin;
      s2 <= s1;
      s3 <= s2;
      for (int u = 0; u < 2; u++) begin
        if (s2[u] == s3[u]) lvl[u] <= s3[u];
      end
    end
  end

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      edge_r[u] = (s2[u] == s3[u]) && s3[u] && !lvl[u];
      edge_f[u] = (s2[u] == s3[u]) && !s3[u] && lvl[u];
      take[u] = (edge_r[u] && rise_on[u]) || (edge_f[u] && fall_on[u]);
      if (chain_join[u] && (32'(up_sel[u]) != u)) begin
        take[u] = take[u] && (captured_edge_count[up_sel[u]] != `PTT_RST_CNT);
      end
    end
  end

  // Unit status and control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_on <= 2'h0;
      fall_on <= 2'h0;
      chain_last_flag <= 2'h0;
      up_sel <= 2'h0;
      chain_join <= 2'h0;
    end else if (bus_wr && paddr == `PTT_OFS_TS_STATUS) begin
      rise_on[ts_idx] <= pwdata[`PTT_TS_RISE_BIT];
      fall_on[ts_idx] <= pwdata[`PTT_TS_FALL_BIT];
      chain_last_flag[ts_idx] <= pwdata[`PTT_TS_LAST_BIT];
      up_sel[ts_idx] <= pwdata[`PTT_TS_UPSEL_BIT];
      chain_join[ts_idx] <= pwdata[`PTT_TS_JOIN_BIT];
    end
  end

  // Event count and overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_edge_count[0] <= `PTT_RST_CNT;
      captured_edge_count[1] <= `PTT_RST_CNT;
      captured_edge_overflow <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (take[u]) begin
          // saturate at 15, overflow only outside cascade or at tail
          if (captured_edge_count[u] == `PTT_CNT_MAX) begin
            if (!chain_join[u] || chain_last_flag[u]) captured_edge_overflow[u] <= 1'b1;
          end else begin
            captured_edge_count[u] <= captured_edge_count[u] + 4'h1;
          end
        end else if (bus_wr && paddr == `PTT_OFS_TS_STATUS && 32'(ts_idx) == u &&
                     !rise_on[u] && !fall_on[u] &&
                     (pwdata[`PTT_TS_RISE_BIT] || pwdata[`PTT_TS_FALL_BIT])) begin
          captured_edge_count[u] <= `PTT_RST_CNT;
          captured_edge_overflow[u] <= 1'b0;
        end
      end
    end
  end

  // Capture report
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot <= 3'h0;
      cap_valid <= 1'b0;
      cap_unit <= 1'b0;
      sample_edge_polarity <= 1'b0;
      sample_sub_slot_phase <= 3'h0;
    end else begin
      slot <= (slot == 3'(`PTT_SLOTS - 1)) ? 3'h0 : slot + 3'h1;
      cap_valid <= |take;
      if (|take) begin
        cap_unit <= !take[0];
        sample_edge_polarity <= take[0] ? edge_r[0] : edge_r[1];
        // 8 ns slot in 40 ns
        sample_sub_slot_phase <= slot;
      end
    end
  end
endmodule
`default_nettype wire

// file: ptt_checker.sv
// Port checks on the trigger and timestamp block
`timescale 1ns/1ps
`default_nettype none
module ptt_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Trigger engine
  input wire logic       trig_start,
  input wire logic [2:0] trig_mode,
  input wire logic       trig_cascade,
  input wire logic       trig_busy,
  input wire logic       trig_out,
  input wire logic       chain_next_valid,
  // Capture report
  input wire logic       cap_valid,
  input wire logic [2:0] sample_sub_slot_phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic start_ok;
  assign start_ok = trig_start && !trig_busy && (trig_mode != 3'h7);

  // ==========================================
  // Register bus
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  apb_wait_a: assert property ((psel && !penable) ##1 (psel && penable)
    |-> ##1 !pready ##1 pready) else $error("bus answer not on the third edge");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  // ==========================================
  // Trigger engine
  busy_start_a: assert property (start_ok |=> trig_busy [*6])
    else $error("busy not held through load");
  pulse_launch_a: assert property (start_ok && trig_mode == 3'h3
    |=> !trig_out [*7] ##1 trig_out) else $error("pulse not launched on time");
  next_valid_a: assert property (start_ok && trig_cascade |-> ##8 chain_next_valid)
    else $error("chain target not produced at fire");
  next_pulse_a: assert property (chain_next_valid |=> !chain_next_valid)
    else $error("chain target strobe too long");

  // ==========================================
  // Capture report
  phase_range_a: assert property (cap_valid |-> sample_sub_slot_phase <= 3'h4)
    else $error("sub slot phase out of range");

  cover property (chain_next_valid);
  cover property (cap_valid && $past(cap_valid, 2) == 1'b0);
  cover property (pslverr);
endmodule

bind ptt_top ptt_checker ptt_checker_inst (.clk, .rst_n, .psel, .penable, .pready, .pslverr,
  .trig_start, .trig_mode, .trig_cascade, .trig_busy, .trig_out, .chain_next_valid,
  .cap_valid, .sample_sub_slot_phase);
`default_nettype wire

// file: ptt_partner.sv
// Event source standing in for the equipment on the timestamp pins
`timescale 1ns/1ps
`default_nettype none
module ptt_partner (
  // Clock
  input  wire logic       clk,
  // Event pins
  output var logic  [1:0] ts_pin
);
  initial ts_pin = 2'h0;

  task automatic toggle(input int u);
    repeat (6) @(posedge clk);
    ts_pin[u] <= ~ts_pin[u];
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: test_ptp_trigger_timestamp_ctl.sv
// Self-checking bench for the trigger and timestamp block
`timescale 1ns/1ps
`default_nettype none
`include "ptt_defs.svh"
module test_ptp_trigger_timestamp_ctl;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, nt, trig_target, chain_next_target;
  logic        trig_start, trig_second_pulse, trig_cascade, trig_out, trig_busy;
  logic        chain_next_valid, cap_valid, cap_unit, sample_edge_polarity, pol, cu, nv;
  logic [1:0]  trig_unit, ts_pin;
  logic [2:0]  trig_mode, sample_sub_slot_phase;
  logic        w[$];
  int          mismatches, checked, cycles, caps, rises, highs, first, last;

  ptt_top ptt_top_inst (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .trig_start, .trig_unit, .trig_mode, .trig_second_pulse,
    .trig_cascade, .trig_target, .trig_out, .trig_busy, .chain_next_target,
    .chain_next_valid, .ts_pin, .cap_valid, .cap_unit, .sample_edge_polarity,
    .sample_sub_slot_phase);
  ptt_partner ptt_partner_inst (.clk, .ts_pin);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cap_valid === 1'b1) begin
      caps++;
      pol = sample_edge_polarity;
      cu = cap_unit;
    end
    if (cycles == 90000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start a run and record the output until busy falls
  task automatic run(input logic [2:0] m, input logic [1:0] u, input logic s, input logic c);
    w = {};
    nv = 1'b0;
    @(posedge clk);
    trig_start <= 1'b1;
    trig_mode <= m;
    trig_unit <= u;
    trig_second_pulse <= s;
    trig_cascade <= c;
    @(posedge clk);
    trig_start <= 1'b0;
    do begin
      @(posedge clk);
      w.push_back(trig_out);
      if (chain_next_valid === 1'b1) begin
        nt = chain_next_target;
        nv = 1'b1;
      end
    end while (trig_busy === 1'b1);
    rises = 0;
    highs = 0;
    for (int i = 0; i < w.size(); i++) begin
      if (w[i] === 1'b1) highs++;
      if (w[i] === 1'b1 && (i == 0 || w[i-1] === 1'b0)) begin
        if (rises == 0) first = i;
        last = i;
        rises++;
      end
    end
  endtask

  task automatic s_regs();
    for (int u = 0; u < 4; u++) begin
      apb(1'b1, `PTT_OFS_UNIT_INDEX, u);
      apb(1'b1, `PTT_OFS_CYCLE_WIDTH, 32'h0000_0100 + u);
    end
    for (int u = 3; u >= 0; u--) begin
      apb(1'b1, `PTT_OFS_UNIT_INDEX, u);
      apb(1'b0, `PTT_OFS_CYCLE_WIDTH, 32'h0);
      chk(rd, 32'h0000_0100 + u);
    end
    apb(1'b1, `PTT_OFS_PULSE_WIDTHS, 32'hffab_cd12);
    apb(1'b0, `PTT_OFS_PULSE_WIDTHS, 32'h0);
    chk(rd, 32'h00ab_cd12);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, `PTT_OFS_TS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic s_trigger();
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h1);
    apb(1'b1, `PTT_OFS_PULSE_WIDTHS, 32'h0005_0003);
    run(3'h3, 2'h1, 1'b0, 1'b0);
    chk(highs, 3);
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h3);
    apb(1'b1, `PTT_OFS_PULSE_WIDTHS, 32'h0001_0000);
    run(3'h3, 2'h3, 1'b1, 1'b0);
    chk(highs, 65536);
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h0);
    apb(1'b1, `PTT_OFS_CYCLE_WIDTH, 32'd40);
    apb(1'b1, `PTT_OFS_COUNT_PATTERN, 32'h0003_0000);
    apb(1'b1, `PTT_OFS_PULSE_WIDTHS, 32'h0000_0002);
    run(3'h5, 2'h0, 1'b0, 1'b0);
    chk(rises, 3);
    chk(highs, 6);
    chk(last - first, 10);
    apb(1'b1, `PTT_OFS_CYCLE_WIDTH, 32'd8);
    apb(1'b1, `PTT_OFS_COUNT_PATTERN, 32'h0004_b000);
    run(3'h6, 2'h0, 1'b0, 1'b0);
    chk({28'h0, w[first], w[first+1], w[first+2], w[first+3]}, 32'hb);
    chk(highs, 3);
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h2);
    apb(1'b1, `PTT_OFS_ITERATION, 32'h0000_0320);
    apb(1'b1, `PTT_OFS_PULSE_WIDTHS, 32'h0000_0001);
    trig_target <= 32'h1000_0000;
    run(3'h3, 2'h2, 1'b0, 1'b1);
    chk({31'h0, nv}, 32'h1);
    chk(nt, 32'h1000_0320);
    trig_target <= 32'hffff_ff00;
    run(3'h3, 2'h2, 1'b0, 1'b1);
    chk(nt, 32'h0000_0220);
  endtask

  // Reset between runs clears registers but keeps the settings store
  task automatic s_reset();
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h0000_0102);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, trig_busy, trig_out}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, `PTT_OFS_UNIT_INDEX, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PTT_OFS_CYCLE_WIDTH, 32'h0);
    chk(rd, 32'd8);
  endtask

  task automatic s_capture();
    int c0;
    c0 = caps;
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h0);
    apb(1'b1, `PTT_OFS_TS_STATUS, 32'h0000_0080);
    ptt_partner_inst.toggle(0);
    chk(caps - c0, 1);
    chk({31'h0, pol}, 32'h1);
    chk({31'h0, cu}, 32'h0);
    ptt_partner_inst.toggle(0);
    chk(caps - c0, 1);
    apb(1'b0, `PTT_OFS_TS_STATUS, 32'h0);
    chk(rd, 32'h0002_0080);
    apb(1'b1, `PTT_OFS_TS_STATUS, 32'h0000_00c0);
    for (int i = 0; i < 16; i++) begin
      ptt_partner_inst.toggle(0);
      if (i == 1) chk({31'h0, pol}, 32'h0);
    end
    apb(1'b0, `PTT_OFS_TS_STATUS, 32'h0);
    chk(rd, 32'h001f_00c0);
    apb(1'b1, `PTT_OFS_TS_STATUS, 32'h0);
    // head unit keeps upstream select zero
    apb(1'b1, `PTT_OFS_TS_STATUS, 32'h0000_00c1);
    apb(1'b0, `PTT_OFS_TS_STATUS, 32'h0);
    chk(rd, 32'h0000_00c1);
    apb(1'b1, `PTT_OFS_UNIT_INDEX, 32'h0000_0100);
    apb(1'b1, `PTT_OFS_TS_STATUS, 32'h0000_00a1);
    c0 = caps;
    ptt_partner_inst.toggle(1);
    chk(caps - c0, 0);
    ptt_partner_inst.toggle(1);
    ptt_partner_inst.toggle(0);
    ptt_partner_inst.toggle(1);
    chk(caps - c0, 2);
    chk({31'h0, cu}, 32'h1);
    apb(1'b0, `PTT_OFS_TS_STATUS, 32'h0);
    chk(rd, 32'h0002_00a1);
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {trig_start, trig_unit, trig_mode, trig_second_pulse, trig_cascade, trig_target} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_trigger();
    s_reset();
    s_capture();
    test_done();
  end
endmodule
`default_nettype wire
